// file: inc/mpr_regs.vh
// Register offsets, field positions, reset values and sizes of the multipurpose pin block.
`ifndef MPR_REGS_VH
`define MPR_REGS_VH

// Byte offsets of the registers on the register port.
`define MPR_PIN0_CFG_ADDR 8'h72
`define MPR_PIN5_CFG_ADDR 8'h77
`define MPR_PIN6_CFG_ADDR 8'h78
`define MPR_PIN7_CFG_ADDR 8'h79
`define MPR_IRQ_STATUS_ADDR 8'h7a
`define MPR_BUCK1_ROUTE_ADDR 8'h7b
`define MPR_BUCK2_ROUTE_ADDR 8'h7c
`define MPR_BUCK3_ROUTE_ADDR 8'h7d
`define MPR_USB_ROUTE_ADDR 8'h7e

// Field positions inside a pin configuration register.
`define MPR_PIN_LEVEL_BIT 7
`define MPR_PIN_OUT_BIT 4
`define MPR_PIN_DRIVE_BIT 3
`define MPR_PIN_DIR_BIT 2
`define MPR_PIN_RES_BIT 1
`define MPR_PIN_PULL_BIT 0
`define MPR_PIN_CFG_WIDTH 5

// Field positions inside a routing register and the status register.
`define MPR_ROUTE_FLAG_BIT 7
`define MPR_ROUTE_SEL_WIDTH 7
`define MPR_STS_BUCK1_BIT 0
`define MPR_STS_BUCK2_BIT 1
`define MPR_STS_BUCK3_BIT 2
`define MPR_STS_USB_BIT 3

// Reset values.
`define MPR_CFG_RESET 5'h00
`define MPR_SEL_RESET 7'h00
`define MPR_FLAG_RESET 1'b0
`define MPR_RDATA_RESET 8'h00

// Sizes and timing counts.
`define MPR_NUM_PINS 8
`define MPR_NUM_SRC 4
`define MPR_PRIME_CYCLES 2'h3

`endif

// file: logic/mpr_pin.v
// One multipurpose pin: its configuration register, input synchroniser and pad drive.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_regs.vh"

module mpr_pin #(
	parameter [7:0] CFG_ADDR = 8'h72
) (
	input wire sys_clk_in,
	input wire resetn_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire irq_routed_in,
	input wire irq_req_in,
	input wire pad_in,
	output reg pad_out,
	output reg pad_oe_out,
	output reg pull_en_out,
	output reg pull_up_out,
	output wire [7:0] readback_out
);

	reg [`MPR_PIN_CFG_WIDTH-1:0] cfg_reg;
	reg sync1_reg;
	reg sync2_reg;
	reg value_next;
	reg oe_next;
	reg out_next;
	reg pull_en_next;
	reg pull_up_next;
	wire dir_w;
	wire od_w;

	assign dir_w = cfg_reg[`MPR_PIN_DIR_BIT];
	assign od_w = cfg_reg[`MPR_PIN_DRIVE_BIT];

	// Level readback sits in bit 7, the written fields in the low bits, the rest read zero.
	assign readback_out = {sync2_reg, 2'b00, cfg_reg};

	// Pad drive: a routed pin carries the active-low request, otherwise the written value.
	always @* begin
		value_next = irq_routed_in ? ~irq_req_in : cfg_reg[`MPR_PIN_OUT_BIT];
		// Open drain pulls low for a 0 and releases for a 1; push-pull drives both levels.
		oe_next = dir_w & (od_w ? ~value_next : 1'b1);
		out_next = od_w ? 1'b0 : value_next;
		// The resistor only applies while the output buffer is off.
		pull_en_next = ~dir_w & cfg_reg[`MPR_PIN_RES_BIT];
		pull_up_next = pull_en_next & cfg_reg[`MPR_PIN_PULL_BIT];
	end

	// Configuration storage, pad sampling and registered pad controls.
	always @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_reg <= `MPR_CFG_RESET;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			pad_out <= 1'b0;
			pad_oe_out <= 1'b0;
			pull_en_out <= 1'b0;
			pull_up_out <= 1'b0;
		end else begin
			if (reg_wr_in && (reg_addr_in == CFG_ADDR)) begin
				cfg_reg <= reg_wdata_in[`MPR_PIN_CFG_WIDTH-1:0];
			end
			// The sensed level passes two flip-flops before anything reads it.
			sync1_reg <= pad_in;
			sync2_reg <= sync1_reg;
			pad_out <= out_next;
			pad_oe_out <= oe_next;
			pull_en_out <= pull_en_next;
			pull_up_out <= pull_up_next;
		end
	end

endmodule
`default_nettype wire

// file: logic/mpr_top.v
// Multipurpose pin configuration and power-good interrupt routing onto the pins.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_regs.vh"

module mpr_top (
	input wire sys_clk_in,
	input wire resetn_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	output reg reg_rvalid_out,
	input wire [2:0] power_good_in,
	input wire usb_input_ok_in,
	input wire [`MPR_NUM_PINS-1:0] pad_in,
	output wire [`MPR_NUM_PINS-1:0] pad_out,
	output wire [`MPR_NUM_PINS-1:0] pad_oe_out,
	output wire [`MPR_NUM_PINS-1:0] pull_en_out,
	output wire [`MPR_NUM_PINS-1:0] pull_up_out
);

	localparam SELW = `MPR_ROUTE_SEL_WIDTH;

	// Source order inside the flat vectors: buck1, buck2, buck3, usb input ok.
	wire [`MPR_NUM_SRC-1:0] src_raw_w;
	wire [`MPR_NUM_SRC-1:0] flag_w;
	wire [`MPR_NUM_SRC*SELW-1:0] sel_w;
	wire [(`MPR_NUM_SRC+1)*8-1:0] src_rd_acc_w;
	wire [`MPR_NUM_PINS*8-1:0] rb_w;
	wire [(`MPR_NUM_PINS+1)*8-1:0] pin_rd_acc_w;
	reg [1:0] prime_cnt_reg;
	reg [7:0] rdata_next;
	wire primed_w;

	assign src_raw_w = {usb_input_ok_in, power_good_in};
	assign primed_w = (prime_cnt_reg == `MPR_PRIME_CYCLES);
	assign src_rd_acc_w[7:0] = 8'h00;
	assign pin_rd_acc_w[7:0] = 8'h00;

	// Hold off change detection until the synchronisers carry real samples after reset.
	// Without it a source that is already high at release would raise a false flag.
	always @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prime_cnt_reg <= 2'h0;
		end else if (!primed_w) begin
			prime_cnt_reg <= prime_cnt_reg + 2'h1;
		end
	end

	// One routing register and change detector per interrupt source.
	genvar gs;
	generate
		for (gs = 0; gs < `MPR_NUM_SRC; gs = gs + 1) begin : g_src
			// The offset sum is 32 bits wide; only its low byte is an address.
			localparam [31:0] RADDR_W = `MPR_BUCK1_ROUTE_ADDR + gs;
			localparam [7:0] RADDR = RADDR_W[7:0];
			reg sync1_reg;
			reg sync2_reg;
			reg prev_reg;
			reg flag_reg;
			reg [SELW-1:0] sel_reg;
			wire wr_hit_w;
			wire rd_hit_w;
			wire change_w;

			assign wr_hit_w = reg_wr_in && (reg_addr_in == RADDR);
			assign rd_hit_w = reg_rd_in && (reg_addr_in == RADDR);
			assign change_w = primed_w && (sync2_reg != prev_reg);

			// Sampling, select storage and the sticky change flag.
			always @(posedge sys_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					sync1_reg <= 1'b0;
					sync2_reg <= 1'b0;
					prev_reg <= 1'b0;
					flag_reg <= `MPR_FLAG_RESET;
					sel_reg <= `MPR_SEL_RESET;
				end else begin
					sync1_reg <= src_raw_w[gs];
					sync2_reg <= sync1_reg;
					prev_reg <= sync2_reg;
					if (wr_hit_w) begin
						sel_reg <= reg_wdata_in[SELW-1:0];
					end
					// A change in the same cycle as the clearing read keeps the flag set.
					if (change_w) begin
						flag_reg <= 1'b1;
					end else if (rd_hit_w) begin
						flag_reg <= 1'b0;
					end
				end
			end

			assign flag_w[gs] = flag_reg;
			assign sel_w[gs*SELW +: SELW] = sel_reg;
			// Read view: flag in bit 7 above the seven select bits.
			assign src_rd_acc_w[(gs+1)*8 +: 8] = src_rd_acc_w[gs*8 +: 8] |
				((reg_addr_in == RADDR) ? {flag_reg, sel_reg} : 8'h00);
		end
	endgenerate

	// One pad per pin; only pins below the select width can carry routed interrupts.
	genvar gp;
	generate
		for (gp = 0; gp < `MPR_NUM_PINS; gp = gp + 1) begin : g_pin
			// The offset sum is 32 bits wide; only its low byte is an address.
			localparam [31:0] PADDR_W = `MPR_PIN0_CFG_ADDR + gp;
			localparam [7:0] PADDR = PADDR_W[7:0];
			wire routed_w;
			wire req_w;

			if (gp < SELW) begin : g_routed
				// Any source may select this pin; the pin reports their OR.
				assign routed_w = sel_w[gp] | sel_w[SELW+gp] |
					sel_w[2*SELW+gp] | sel_w[3*SELW+gp];
				assign req_w = (sel_w[gp] & flag_w[0]) |
					(sel_w[SELW+gp] & flag_w[1]) |
					(sel_w[2*SELW+gp] & flag_w[2]) |
					(sel_w[3*SELW+gp] & flag_w[3]);
			end else begin : g_plain
				assign routed_w = 1'b0;
				assign req_w = 1'b0;
			end

			mpr_pin #(
				.CFG_ADDR(PADDR)
			) u_pin (
				.sys_clk_in(sys_clk_in),
				.resetn_in(resetn_in),
				.reg_addr_in(reg_addr_in),
				.reg_wdata_in(reg_wdata_in),
				.reg_wr_in(reg_wr_in),
				.irq_routed_in(routed_w),
				.irq_req_in(req_w),
				.pad_in(pad_in[gp]),
				.pad_out(pad_out[gp]),
				.pad_oe_out(pad_oe_out[gp]),
				.pull_en_out(pull_en_out[gp]),
				.pull_up_out(pull_up_out[gp]),
				.readback_out(rb_w[gp*8 +: 8])
			);

			assign pin_rd_acc_w[(gp+1)*8 +: 8] = pin_rd_acc_w[gp*8 +: 8] |
				((reg_addr_in == PADDR) ? rb_w[gp*8 +: 8] : 8'h00);
		end
	endgenerate

	// Read mux: pin registers, routing registers and the summary status; other offsets read zero.
	always @* begin
		rdata_next = pin_rd_acc_w[`MPR_NUM_PINS*8 +: 8] | src_rd_acc_w[`MPR_NUM_SRC*8 +: 8];
		if (reg_addr_in == `MPR_IRQ_STATUS_ADDR) begin
			rdata_next = {4'h0, flag_w};
		end
	end

	// Read data is captured on the read strobe and held until the next read.
	always @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= `MPR_RDATA_RESET;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_next;
			end
		end
	end

endmodule
`default_nettype wire

// file: verification/mpr_top_asserts.sv
// Port-level checker for the multipurpose pin block.
`timescale 1ns/100ps
`default_nettype none
module mpr_top_chk (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic [2:0] power_good_in,
	input wire logic [7:0] pad_in,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_out,
	input wire logic [7:0] pull_en_out,
	input wire logic [7:0] pull_up_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] wd1;
	logic [7:0] wd2;
	// Delays write data so that it lines up with the pad outputs two edges on.
	always_ff @(posedge sys_clk_in) begin
		wd1 <= reg_wdata_in;
		wd2 <= wd1;
	end
	chk_read_once: assert property (
		reg_rd_in ##1 !reg_rd_in |-> reg_rvalid_out ##1 !reg_rvalid_out)
		else $error("read valid not one cycle");
	chk_rdata_hold: assert property (
		!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	chk_status_rsvd: assert property (
		reg_rd_in && reg_addr_in == 8'h7a |=> reg_rdata_out[7:4] == 4'h0)
		else $error("status upper bits not zero");
	chk_pull_input: assert property (
		(pull_en_out & pad_oe_out) == 8'h00)
		else $error("pull resistor on a driven pin");
	chk_pin0_input: assert property (
		reg_wr_in && reg_addr_in == 8'h72 && !reg_wdata_in[2] ##1 !(reg_wr_in && reg_addr_in == 8'h72)
		|=> !pad_oe_out[0] && pull_en_out[0] == wd2[1] && pull_up_out[0] == (wd2[1] && wd2[0]))
		else $error("pin 0 input setup not applied");
	chk_pin7_drive: assert property (
		reg_wr_in && reg_addr_in == 8'h79 && reg_wdata_in[2] ##1 !(reg_wr_in && reg_addr_in == 8'h79)
		|=> pad_oe_out[7] == !(wd2[3] && wd2[4]) && pad_out[7] == (wd2[4] && !wd2[3]))
		else $error("pin 7 output drive wrong");
	chk_level_sync: assert property (
		$stable(pad_in[7]) [*3] ##0 (reg_rd_in && reg_addr_in == 8'h79)
		|=> reg_rdata_out[7] == $past(pad_in[7]))
		else $error("pin 7 level readback wrong");
	chk_flag_set: assert property (
		$changed(power_good_in[0]) ##1 !(reg_rd_in && reg_addr_in == 8'h7b) [*5]
		##0 (reg_rd_in && reg_addr_in == 8'h7a) |=> reg_rdata_out[0])
		else $error("buck1 change not flagged");
endmodule
bind mpr_top mpr_top_chk mpr_top_chk_inst (.*);
`default_nettype wire

// file: verification/mpr_pad_model.sv
// Outside logic and wiring that settle the level seen on each pin.
`timescale 1ns/100ps
`default_nettype none
module mpr_pad_model (
	input wire logic clk_in,
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] pull_en_in,
	input wire logic [7:0] pull_up_in,
	input wire logic [7:0] ext_en_in,
	input wire logic [7:0] ext_val_in,
	output logic [7:0] level_out
);
	logic wander_reg = 1'b0;
	// A pin that nobody holds drifts each cycle, so no stale level survives.
	always @(posedge clk_in) wander_reg <= ~wander_reg;
	// Device drive first, then outside drive, then the pull resistor.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (oe_in[i]) level_out[i] = drv_in[i];
			else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
			else if (pull_en_in[i]) level_out[i] = pull_up_in[i];
			else level_out[i] = wander_reg;
		end
	end
endmodule
`default_nettype wire

// file: verification/tb_mpr_top.sv
// Self-checking bench for the multipurpose pin block.
`timescale 1ns/100ps
`default_nettype none
module tb_mpr_top;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [3:0] src = 4'h0;
	logic [7:0] ext_en = 8'hff;
	logic [7:0] ext_val = 8'h00;
	wire [7:0] reg_rdata_out, pad_in, pad_out, pad_oe_out, pull_en_out, pull_up_out;
	wire reg_rvalid_out;
	wire [2:0] power_good_in = src[2:0];
	wire usb_input_ok_in = src[3];
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	mpr_top mpr_top_inst (.*);
	mpr_pad_model mpr_pad_model_inst (.clk_in(sys_clk_in), .drv_in(pad_out),
		.oe_in(pad_oe_out), .pull_en_in(pull_en_out), .pull_up_in(pull_up_out),
		.ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
	// Free-running clock.
	initial forever #5 sys_clk_in = ~sys_clk_in;
	task automatic results();
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			results();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge sys_clk_in);
		check(reg_rdata_out, exp);
		check({7'h00, reg_rvalid_out}, 8'h01);
	endtask
	// Main sequence of register traffic and pin activity.
	initial begin
		int i;
		logic v;
		logic od;
		logic [7:0] sel;
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		for (i = 8'h72; i <= 8'h80; i++) rd(i[7:0], 8'h00);
		for (i = 0; i < 8; i++) wr(8'h72 + i[7:0], 8'he3);
		for (i = 0; i < 8; i++) rd(8'h72 + i[7:0], 8'h03);
		check(pull_up_out, 8'hff);
		for (i = 0; i < 8; i++) wr(8'h72 + i[7:0], 8'h02);
		repeat (2) @(negedge sys_clk_in);
		check(pull_en_out, 8'hff);
		check(pull_up_out, 8'h00);
		@(posedge sys_clk_in);
		ext_val <= 8'ha5;
		repeat (3) @(posedge sys_clk_in);
		for (i = 0; i < 8; i++) rd(8'h72 + i[7:0], {ext_val[i], 7'h02});
		@(posedge sys_clk_in);
		ext_en <= 8'h00;
		for (i = 0; i < 4; i++) begin
			v = i[0];
			od = i[1];
			wr(8'h79, {3'h0, v, od, 3'h4});
			repeat (4) @(negedge sys_clk_in);
			check({6'h00, pad_oe_out[7], pad_out[7]}, {6'h00, !(od && v), v && !od});
			if (!(od && v)) rd(8'h79, {v, 2'h0, v, od, 3'h4});
		end
		for (i = 0; i < 7; i++) wr(8'h72 + i[7:0], 8'h1c);
		for (i = 0; i < 4; i++) begin
			sel = 8'h01 << (2 * i);
			wr(8'h7b + i[7:0], 8'h80 | sel);
			rd(8'h7b + i[7:0], sel);
			@(posedge sys_clk_in);
			src <= src ^ (4'h1 << i);
			repeat (4) @(posedge sys_clk_in);
			rd(8'h7a, 8'h01 << i);
			check(pad_oe_out, sel);
			check(pad_out, 8'h00);
			rd(8'h7b + i[7:0], 8'h80 | sel);
			rd(8'h7b + i[7:0], sel);
			check(pad_oe_out, 8'h00);
		end
		results();
	end
endmodule
`default_nettype wire
